// ===== logic/lhps_pkg.sv
// Shared constants for the host port and multi-chip sync block
package lhps_pkg;
  localparam int BUS_W = 8;
  localparam int SER_DATA_BIT = 7;
  localparam int SER_CLK_BIT = 6;
  localparam logic [2:0] SER_LAST_BIT = 3'h7;
  localparam logic [2:0] SER_FIRST_BIT = 3'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam int CLK_PERIOD_NS = 100;
  localparam int RESET_MIN_NS = 5000;
  localparam int RESET_MIN_CYC_I = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_CNT_W = 7;
  localparam logic [INIT_CNT_W-1:0] RESET_MIN_CYC = INIT_CNT_W'(RESET_MIN_CYC_I);
  localparam logic [INIT_CNT_W-1:0] INIT_CNT_ZERO = 7'h00;
  localparam logic [INIT_CNT_W-1:0] INIT_CNT_ONE = 7'h01;
  typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ} lhps_bus_e;
endpackage

// ===== logic/lhps_serial_rx.sv
// Two-wire serial byte receiver, write only
`timescale 1ns/1ps
module lhps_serial_rx
  import lhps_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic enable,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic dc_sel,
  output logic byte_valid,
  output logic [BUS_W-1:0] byte_data,
  output logic byte_dc
);
  logic ser_clk_prev;
  logic [2:0] bit_cnt;
  logic [BUS_W-1:0] shift;
  logic rise;

  assign rise = enable && ser_clk && !ser_clk_prev;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ser_clk_prev <= 1'b0;
    end else if (clk_en) begin
      ser_clk_prev <= ser_clk;
    end
  end

  // Deselecting drops a partial byte so the next select starts aligned
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bit_cnt <= SER_FIRST_BIT;
      shift <= BYTE_ZERO;
      byte_valid <= 1'b0;
      byte_data <= BYTE_ZERO;
      byte_dc <= 1'b0;
    end else if (clk_en) begin
      byte_valid <= 1'b0;
      if (!enable) begin
        bit_cnt <= SER_FIRST_BIT;
      end else if (rise) begin
        shift <= {shift[BUS_W-2:0], ser_data};
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == SER_LAST_BIT) begin
          byte_valid <= 1'b1;
          byte_data <= {shift[BUS_W-2:0], ser_data};
          byte_dc <= dc_sel;
        end
      end
    end
  end

  property p_ser_byte;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && rise && bit_cnt == SER_LAST_BIT) |=>
        byte_valid && byte_dc == $past(dc_sel) && byte_data[0] == $past(ser_data);
  endproperty
  a_ser_byte: assert property (p_ser_byte) else $error("serial byte not completed");

  cover property (@(posedge sys_clk) disable iff (srst) byte_valid);
endmodule

// ===== logic/lhps_host_port.sv
// Host bus port, serial input and master/slave sync lines
`timescale 1ns/1ps
module lhps_host_port
  import lhps_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic chip_init_n,
  input wire logic parallel_sel,
  input wire logic bus_style_sel,
  input wire logic master_sel,
  input wire logic internal_osc_on,
  input wire logic select_low_n,
  input wire logic select_high,
  input wire logic dc_sel,
  input wire logic rw_wr_n,
  input wire logic en_rd_n,
  input wire logic [BUS_W-1:0] host_bus_in,
  output logic [BUS_W-1:0] host_bus_out,
  output logic host_bus_oe,
  input wire logic [BUS_W-1:0] rd_data,
  input wire logic [BUS_W-1:0] status_data,
  output logic rd_req,
  output logic rd_is_data,
  output logic data_wr_valid,
  output logic cmd_wr_valid,
  output logic [BUS_W-1:0] wr_byte,
  output logic init_busy,
  output logic init_done,
  output logic init_short,
  input wire logic osc_tick,
  input wire logic frame_int,
  input wire logic blanking_int,
  input wire logic indicator_int,
  input wire logic display_tick_in,
  output logic display_tick_out,
  output logic display_tick_oe,
  input wire logic frame_toggle_in,
  output logic frame_toggle_out,
  output logic frame_toggle_oe,
  input wire logic blanking_link_in,
  output logic blanking_link_out,
  output logic blanking_link_oe,
  output logic indicator_out,
  output logic indicator_oe,
  output logic display_tick,
  output logic frame_seen,
  output logic blanking_seen
);
  lhps_bus_e bus_state;
  logic wr_prev;
  logic rd_prev;
  logic init_prev;
  logic [INIT_CNT_W-1:0] init_cnt;
  logic sel_ok;
  logic port_ok;
  logic style_68;
  logic start_wr;
  logic start_rd;
  logic end_wr;
  logic end_rd;
  logic ser_valid;
  logic [BUS_W-1:0] ser_byte;
  logic ser_dc;
  logic wr_from_ser;

  function automatic logic rose(input logic prev, input logic cur);
    return !prev && cur;
  endfunction

  function automatic logic fell(input logic prev, input logic cur);
    return prev && !cur;
  endfunction

  assign sel_ok = !select_low_n && select_high;
  assign port_ok = sel_ok && !init_busy && chip_init_n;
  assign style_68 = bus_style_sel;

  // Strobe decode; the 6800 direction is sampled at the enable edge
  always_comb begin
    start_wr = 1'b0;
    start_rd = 1'b0;
    end_wr = 1'b0;
    end_rd = 1'b0;
    if (parallel_sel && port_ok && bus_state == BUS_IDLE) begin
      if (style_68) begin
        start_wr = rose(rd_prev, en_rd_n) && !rw_wr_n;
        start_rd = rose(rd_prev, en_rd_n) && rw_wr_n;
      end else begin
        start_wr = fell(wr_prev, rw_wr_n);
        start_rd = fell(rd_prev, en_rd_n) && !start_wr;
      end
    end
    if (bus_state == BUS_WRITE && sel_ok) begin
      end_wr = style_68 ? fell(rd_prev, en_rd_n) : rose(wr_prev, rw_wr_n);
    end
    if (bus_state == BUS_READ) begin
      end_rd = !sel_ok || (style_68 ? fell(rd_prev, en_rd_n) : rose(rd_prev, en_rd_n));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_prev <= 1'b1;
      rd_prev <= 1'b1;
      init_prev <= 1'b1;
    end else if (clk_en) begin
      wr_prev <= rw_wr_n;
      rd_prev <= en_rd_n;
      init_prev <= chip_init_n;
    end
  end

  // Init: low level holds the port idle, width checked on release
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      init_busy <= 1'b0;
      init_done <= 1'b0;
      init_short <= 1'b0;
      init_cnt <= INIT_CNT_ZERO;
    end else if (clk_en) begin
      init_done <= 1'b0;
      if (!chip_init_n) begin
        init_busy <= 1'b1;
        if (init_prev) begin
          init_cnt <= INIT_CNT_ONE;
          init_short <= 1'b0;
        end else if (init_cnt != RESET_MIN_CYC) begin
          init_cnt <= init_cnt + INIT_CNT_ONE;
        end
      end else if (init_busy) begin
        init_busy <= 1'b0;
        init_done <= 1'b1;
        init_short <= (init_cnt != RESET_MIN_CYC);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bus_state <= BUS_IDLE;
    end else if (clk_en) begin
      case (bus_state)
        BUS_IDLE: begin
          if (start_wr) begin
            bus_state <= BUS_WRITE;
          end else if (start_rd) begin
            bus_state <= BUS_READ;
          end
        end
        BUS_WRITE: begin
          if (end_wr || !sel_ok || !parallel_sel || init_busy) begin
            bus_state <= BUS_IDLE;
          end
        end
        BUS_READ: begin
          if (end_rd || !parallel_sel || init_busy) begin
            bus_state <= BUS_IDLE;
          end
        end
        default: begin
          bus_state <= BUS_IDLE;
        end
      endcase
    end
  end

  // Read data is fixed at the start edge; host samples it later in the strobe
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      host_bus_out <= BYTE_ZERO;
      host_bus_oe <= 1'b0;
      rd_req <= 1'b0;
      rd_is_data <= 1'b0;
    end else if (clk_en) begin
      rd_req <= start_rd;
      if (start_rd) begin
        rd_is_data <= dc_sel;
        host_bus_out <= dc_sel ? rd_data : status_data;
        host_bus_oe <= 1'b1;
      end else if (bus_state != BUS_READ || end_rd || !parallel_sel || init_busy) begin
        host_bus_oe <= 1'b0;
      end
    end
  end

  lhps_serial_rx u_serial (
    .sys_clk(sys_clk),
    .srst(srst),
    .clk_en(clk_en),
    .enable(!parallel_sel && port_ok),
    .ser_clk(host_bus_in[SER_CLK_BIT]),
    .ser_data(host_bus_in[SER_DATA_BIT]),
    .dc_sel(dc_sel),
    .byte_valid(ser_valid),
    .byte_data(ser_byte),
    .byte_dc(ser_dc)
  );

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      data_wr_valid <= 1'b0;
      cmd_wr_valid <= 1'b0;
      wr_byte <= BYTE_ZERO;
      wr_from_ser <= 1'b0;
    end else if (clk_en) begin
      data_wr_valid <= 1'b0;
      cmd_wr_valid <= 1'b0;
      wr_from_ser <= 1'b0;
      if (end_wr && parallel_sel && port_ok) begin
        wr_byte <= host_bus_in;
        data_wr_valid <= dc_sel;
        cmd_wr_valid <= !dc_sel;
      end else if (ser_valid && !parallel_sel && chip_init_n && !init_busy) begin
        wr_byte <= ser_byte;
        data_wr_valid <= ser_dc;
        cmd_wr_valid <= !ser_dc;
        wr_from_ser <= 1'b1;
      end
    end
  end

  // Sync lines: frame and blanking pins either drive or are followed, never both; the indicator pin only drives
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      indicator_out <= 1'b0;
      indicator_oe <= 1'b0;
      frame_toggle_out <= 1'b0;
      frame_toggle_oe <= 1'b0;
      blanking_link_out <= 1'b0;
      blanking_link_oe <= 1'b0;
      frame_seen <= 1'b0;
      blanking_seen <= 1'b0;
    end else if (clk_en) begin
      indicator_out <= master_sel && indicator_int;
      indicator_oe <= master_sel;
      frame_toggle_out <= master_sel && frame_int;
      frame_toggle_oe <= master_sel;
      frame_seen <= master_sel ? frame_int : frame_toggle_in;
      blanking_link_out <= master_sel && blanking_int;
      blanking_link_oe <= master_sel;
      blanking_seen <= master_sel ? blanking_int : blanking_link_in;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      display_tick_out <= 1'b0;
      display_tick_oe <= 1'b0;
      display_tick <= 1'b0;
    end else if (clk_en) begin
      display_tick_oe <= master_sel && internal_osc_on;
      display_tick_out <= master_sel && internal_osc_on && osc_tick;
      display_tick <= internal_osc_on ? (master_sel ? osc_tick : display_tick_in)
                                      : display_tick_in;
    end
  end

  property p_ind_master;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && master_sel) |=> indicator_oe && indicator_out == $past(indicator_int);
  endproperty
  a_ind_master: assert property (p_ind_master) else $error("indicator not driven");

  property p_ind_slave;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && !master_sel) |=> !indicator_oe;
  endproperty
  a_ind_slave: assert property (p_ind_slave) else $error("indicator driven as slave");

  property p_frame;
    @(posedge sys_clk) disable iff (srst)
      clk_en |=> frame_toggle_oe == $past(master_sel) &&
        frame_seen == ($past(master_sel) ? $past(frame_int) : $past(frame_toggle_in));
  endproperty
  a_frame: assert property (p_frame) else $error("frame toggle direction wrong");

  property p_tick_out;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && master_sel && internal_osc_on) |=>
        display_tick_oe && display_tick_out == $past(osc_tick);
  endproperty
  a_tick_out: assert property (p_tick_out) else $error("display tick not sourced");

  property p_tick_in;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && !(master_sel && internal_osc_on)) |=>
        !display_tick_oe && display_tick == $past(display_tick_in);
  endproperty
  a_tick_in: assert property (p_tick_in) else $error("display tick not taken in");

  property p_blank;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && !master_sel) |=> !blanking_link_oe && blanking_seen == $past(blanking_link_in);
  endproperty
  a_blank: assert property (p_blank) else $error("blanking not followed");

  property p_select;
    @(posedge sys_clk) disable iff (srst)
      ((data_wr_valid || cmd_wr_valid) && !wr_from_ser) |-> $past(sel_ok);
  endproperty
  a_select: assert property (p_select) else $error("write taken while deselected");

  property p_init;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && !chip_init_n) |=> init_busy ##0 (!rd_req && !data_wr_valid);
  endproperty
  a_init: assert property (p_init) else $error("init not started");

  property p_dc;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && end_wr && parallel_sel && !init_busy && chip_init_n) |=>
        data_wr_valid == $past(dc_sel) && cmd_wr_valid == !$past(dc_sel) &&
        wr_byte == $past(host_bus_in);
  endproperty
  a_dc: assert property (p_dc) else $error("write routed wrong");

  property p_68_read;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && style_68 && start_rd) |=> rd_req && host_bus_oe && $past(rw_wr_n);
  endproperty
  a_68_read: assert property (p_68_read) else $error("6800 read not started");

  property p_80_write;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && !style_68 && parallel_sel && port_ok && bus_state == BUS_IDLE &&
       fell(wr_prev, rw_wr_n)) |=> bus_state == BUS_WRITE;
  endproperty
  a_80_write: assert property (p_80_write) else $error("8080 write not started");

  property p_80_read;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && !style_68 && start_rd) |=> rd_req ##0 host_bus_oe;
  endproperty
  a_80_read: assert property (p_80_read) else $error("8080 read not started");

  property p_hiz;
    @(posedge sys_clk) disable iff (srst)
      host_bus_oe |-> $past(parallel_sel) && $past(sel_ok) && bus_state == BUS_READ;
  endproperty
  a_hiz: assert property (p_hiz) else $error("bus driven outside read");

  cover property (@(posedge sys_clk) disable iff (srst)
    !style_68 && data_wr_valid && !wr_from_ser);
  cover property (@(posedge sys_clk) disable iff (srst) style_68 && rd_req);
  cover property (@(posedge sys_clk) disable iff (srst) cmd_wr_valid && wr_from_ser);
  cover property (@(posedge sys_clk) disable iff (srst) init_done && !init_short);
endmodule

// ===== verification/lhps_far_model.sv
// Far-side model: host bus wire and an external master on the sync pins
`timescale 1ns/1ps
module lhps_far_model
  import lhps_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [BUS_W-1:0] host_drv,
  input wire logic host_drv_on,
  input wire logic [BUS_W-1:0] dev_bus_out,
  input wire logic dev_bus_oe,
  output logic [BUS_W-1:0] bus_wire,
  input wire logic [2:0] ext_sync,
  input wire logic [2:0] dev_sync_out,
  input wire logic [2:0] dev_sync_oe,
  output logic [2:0] sync_wire
);
  logic [BUS_W-1:0] last_bus = BYTE_ZERO;
  // A floating bus flips every cycle so a stale byte can never look valid
  always_comb begin
    if (dev_bus_oe) begin
      bus_wire = dev_bus_out;
    end else if (host_drv_on) begin
      bus_wire = host_drv;
    end else begin
      bus_wire = ~last_bus;
    end
  end
  always @(posedge sys_clk) begin
    last_bus <= bus_wire;
  end
  // External master or clock source drives a sync pin whenever the device lets go
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      sync_wire[i] = dev_sync_oe[i] ? dev_sync_out[i] : ext_sync[i];
    end
  end
endmodule

// ===== verification/tb_lcd_host_port_and_sync.sv
// Self-checking bench for the host port and sync block
`timescale 1ns/1ps
module tb_lcd_host_port_and_sync;
  import lhps_pkg::*;
  logic sys_clk = 1'b0, srst = 1'b1, clk_en = 1'b1, chip_init_n = 1'b1;
  logic parallel_sel = 1'b1, bus_style_sel = 1'b0, master_sel = 1'b1, internal_osc_on = 1'b1;
  logic select_low_n = 1'b0, select_high = 1'b1, dc_sel = 1'b0, rw_wr_n = 1'b1, en_rd_n = 1'b1;
  logic [7:0] host_bus_in, host_bus_out, wr_byte, host_drv = 8'h00;
  logic [7:0] rd_data = 8'h5a, status_data = 8'h81;
  logic host_drv_on = 1'b0, host_bus_oe, rd_req, rd_is_data, data_wr_valid, cmd_wr_valid;
  logic init_busy, init_done, init_short, display_tick, frame_seen, blanking_seen;
  logic osc_tick = 1'b0, frame_int = 1'b0, blanking_int = 1'b0, indicator_int = 1'b0;
  logic display_tick_in, display_tick_out, display_tick_oe, frame_toggle_in, frame_toggle_out;
  logic frame_toggle_oe, blanking_link_in, blanking_link_out, blanking_link_oe;
  logic indicator_out, indicator_oe;
  logic [2:0] ext_sync = 3'b000, sync_wire;
  logic [7:0] cnt_d = 8'h00, cnt_c = 8'h00, cnt_r = 8'h00, cnt_i = 8'h00;
  int fail_count = 0, cmp_count = 0;

  lhps_host_port dut (.sys_clk, .srst, .clk_en, .chip_init_n, .parallel_sel, .bus_style_sel,
    .master_sel, .internal_osc_on, .select_low_n, .select_high, .dc_sel, .rw_wr_n, .en_rd_n,
    .host_bus_in, .host_bus_out, .host_bus_oe, .rd_data, .status_data, .rd_req, .rd_is_data,
    .data_wr_valid, .cmd_wr_valid, .wr_byte, .init_busy, .init_done, .init_short, .osc_tick,
    .frame_int, .blanking_int, .indicator_int, .display_tick_in, .display_tick_out,
    .display_tick_oe, .frame_toggle_in, .frame_toggle_out, .frame_toggle_oe, .blanking_link_in,
    .blanking_link_out, .blanking_link_oe, .indicator_out, .indicator_oe, .display_tick,
    .frame_seen, .blanking_seen);

  lhps_far_model far (.sys_clk, .host_drv, .host_drv_on, .dev_bus_out(host_bus_out),
    .dev_bus_oe(host_bus_oe), .bus_wire(host_bus_in), .ext_sync,
    .dev_sync_out({display_tick_out, frame_toggle_out, blanking_link_out}),
    .dev_sync_oe({display_tick_oe, frame_toggle_oe, blanking_link_oe}), .sync_wire);
  assign {display_tick_in, frame_toggle_in, blanking_link_in} = sync_wire;

  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  // Pulse counters let each transfer be checked for its exact pulse count, one or none
  always @(posedge sys_clk) begin
    if (data_wr_valid === 1'b1) cnt_d <= cnt_d + 8'h01;
    if (cmd_wr_valid === 1'b1) cnt_c <= cnt_c + 8'h01;
    if (rd_req === 1'b1) cnt_r <= cnt_r + 8'h01;
    if (init_done === 1'b1) cnt_i <= cnt_i + 8'h01;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic clr();
    cnt_d = 8'h00;
    cnt_c = 8'h00;
    cnt_r = 8'h00;
    cnt_i = 8'h00;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Strobes are held until sampled and released four cycles before the data goes away
  task automatic bus_wr(input logic m68, input logic dc, input logic [7:0] b, input logic take);
    clr();
    dc_sel = dc;
    host_drv = b;
    host_drv_on = 1'b1;
    rw_wr_n = 1'b0;
    if (m68) begin
      wt(1);
      en_rd_n = 1'b1;
    end
    wt(3);
    chk("bus_oe_in_write", 8'h00, {7'h00, host_bus_oe});
    if (m68) en_rd_n = 1'b0;
    else rw_wr_n = 1'b1;
    wt(4);
    host_drv_on = 1'b0;
    chk("data_pulses", {7'h00, take & dc}, cnt_d);
    chk("cmd_pulses", {7'h00, take & ~dc}, cnt_c);
    if (take) chk("wr_byte", b, wr_byte);
  endtask

  task automatic bus_rd(input logic m68, input logic dc, input logic [7:0] exp);
    clr();
    dc_sel = dc;
    if (m68) begin
      rw_wr_n = 1'b1;
      wt(1);
      en_rd_n = 1'b1;
    end else begin
      en_rd_n = 1'b0;
    end
    wt(3);
    chk("bus_oe_read", 8'h01, {7'h00, host_bus_oe});
    chk("bus_wire_read", exp, host_bus_in);
    chk("rd_req_pulses", 8'h01, cnt_r);
    chk("rd_is_data", {7'h00, dc}, {7'h00, rd_is_data});
    en_rd_n = ~m68;
    wt(3);
    chk("bus_oe_after", 8'h00, {7'h00, host_bus_oe});
  endtask

  task automatic ser_byte(input logic dc, input logic [7:0] b);
    clr();
    dc_sel = dc;
    host_drv_on = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      host_drv = {b[i], 7'h00};
      wt(2);
      host_drv[SER_CLK_BIT] = 1'b1;
      wt(2);
    end
    host_drv = BYTE_ZERO;
    wt(5);
    chk("ser_data_pulses", {7'h00, dc}, cnt_d);
    chk("ser_cmd_pulses", {7'h00, ~dc}, cnt_c);
    chk("ser_byte", b, wr_byte);
  endtask

  initial begin
    repeat (5000) @(posedge sys_clk);
    fail_count++;
    end_sim();
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    wt(1);
    srst = 1'b0;
    wt(2);
    clr();
    chip_init_n = 1'b0;
    wt(2);
    chk("init_busy", 8'h01, {7'h00, init_busy});
    wt(8);
    chip_init_n = 1'b1;
    wt(3);
    chk("init_done_short", 8'h01, cnt_i);
    chk("init_short_set", 8'h01, {7'h00, init_short});
    clr();
    chip_init_n = 1'b0;
    wt(RESET_MIN_CYC_I + 2);
    chip_init_n = 1'b1;
    wt(3);
    chk("init_done_full", 8'h01, cnt_i);
    chk("init_short_clr", 8'h00, {7'h00, init_short});
    chk("init_busy_off", 8'h00, {7'h00, init_busy});
    bus_wr(1'b0, 1'b1, 8'ha5, 1'b1);
    bus_wr(1'b0, 1'b0, 8'h3c, 1'b1);
    select_high = 1'b0;
    bus_wr(1'b0, 1'b1, 8'h77, 1'b0);
    select_high = 1'b1;
    select_low_n = 1'b1;
    bus_wr(1'b0, 1'b0, 8'h77, 1'b0);
    select_low_n = 1'b0;
    bus_rd(1'b0, 1'b1, 8'h5a);
    bus_rd(1'b0, 1'b0, 8'h81);
    select_low_n = 1'b1;
    bus_style_sel = 1'b1;
    en_rd_n = 1'b0;
    wt(2);
    select_low_n = 1'b0;
    bus_wr(1'b1, 1'b1, 8'hc3, 1'b1);
    bus_wr(1'b1, 1'b0, 8'h1e, 1'b1);
    bus_rd(1'b1, 1'b1, 8'h5a);
    select_low_n = 1'b1;
    parallel_sel = 1'b0;
    bus_style_sel = 1'b0;
    en_rd_n = 1'b1;
    rw_wr_n = 1'b1;
    wt(2);
    select_low_n = 1'b0;
    ser_byte(1'b1, 8'h96);
    ser_byte(1'b0, 8'h41);
    bus_wr(1'b0, 1'b1, 8'h15, 1'b0);
    en_rd_n = 1'b0;
    wt(3);
    chk("serial_read_oe", 8'h00, {7'h00, host_bus_oe});
    en_rd_n = 1'b1;
    osc_tick = 1'b1;
    frame_int = 1'b1;
    indicator_int = 1'b1;
    wt(3);
    chk("master_oe", 8'h07, {5'h00, display_tick_oe, frame_toggle_oe, blanking_link_oe});
    chk("master_out", 8'h06, {5'h00, display_tick_out, frame_toggle_out, blanking_link_out});
    chk("indicator_master", 8'h03, {6'h00, indicator_oe, indicator_out});
    clk_en = 1'b0;
    indicator_int = 1'b0;
    wt(3);
    chk("freeze_hold", 8'h03, {6'h00, indicator_oe, indicator_out});
    clk_en = 1'b1;
    wt(3);
    chk("freeze_release", 8'h02, {6'h00, indicator_oe, indicator_out});
    internal_osc_on = 1'b0;
    ext_sync = 3'b100;
    wt(3);
    chk("tick_oe_osc_off", 8'h00, {7'h00, display_tick_oe});
    chk("tick_osc_off", 8'h01, {7'h00, display_tick});
    master_sel = 1'b0;
    internal_osc_on = 1'b1;
    ext_sync = 3'b011;
    wt(3);
    chk("slave_oe", 8'h00, {5'h00, display_tick_oe, frame_toggle_oe, blanking_link_oe});
    chk("indicator_slave", 8'h00, {7'h00, indicator_oe});
    chk("slave_seen", 8'h03, {5'h00, display_tick, frame_seen, blanking_seen});
    ext_sync = 3'b100;
    wt(3);
    chk("slave_seen_flip", 8'h04, {5'h00, display_tick, frame_seen, blanking_seen});
    end_sim();
  end
endmodule
